/* File: rtl/iss_downcounter.v */
// loadable down counter used for tick, delay and line extension timing
`timescale 1ns/1ps
module iss_downcounter (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // control
    input wire load,
    input wire [15:0] load_val,
    input wire tick,
    // status
    output reg [15:0] count_r,
    output wire zero
);
    assign zero = (count_r == 16'h0000);
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= 16'h0000;
        end else if (load) begin
            count_r <= load_val;
        end else if (tick && !zero) begin
            count_r <= count_r - 16'h0001;
        end
    end
endmodule

/* File: rtl/iss_regs.vh */
// register offsets, field positions, reset values for the sequencer configuration block
`ifndef ISS_REGS_VH
`define ISS_REGS_VH
`define ISS_ADDR_GENERAL 9'h0C0
`define ISS_ADDR_DELAY 9'h0C1
`define ISS_ADDR_INTEG 9'h0C2
`define ISS_ADDR_WINDOW 9'h0C3
`define ISS_ADDR_SPARE 9'h0C4
`define ISS_ADDR_DARK 9'h0C5
`define ISS_ADDR_PAD 9'h0C6
`define ISS_ADDR_TBMULT 9'h0C7
`define ISS_ADDR_PERIOD 9'h0C8
`define ISS_ADDR_EXPO 9'h0C9
`define ISS_ADDR_EXPO2 9'h0CA
`define ISS_RST_GENERAL 16'h0000
`define ISS_RST_DELAY 16'h0000
`define ISS_RST_INTEG 16'h0004
`define ISS_RST_WINDOW 16'h0001
`define ISS_RST_SPARE 16'h0000
`define ISS_RST_DARK 16'h0102
`define ISS_RST_PAD 16'h0000
`define ISS_RST_TBMULT 16'h0001
`define ISS_RST_PERIOD 16'h0000
`define ISS_RST_EXPO 16'h0000
`define ISS_RST_EXPO2 16'h0000
`define ISS_MASK_GENERAL 16'h3FF3
`define ISS_MASK_INTEG 16'h0007
`define ISS_MASK_WINDOW 16'h00FF
`define ISS_MASK_DARK 16'h01FF
`define ISS_MASK_PAD 16'h0FFF
`define ISS_BIT_ENABLE 0
`define ISS_BIT_ROLLING 1
`define ISS_BIT_DLY_EN 6
`define ISS_BIT_SUBSAMPLE 7
`define ISS_BIT_BINNING 8
`define ISS_BIT_STAT_WIN 10
`define ISS_BIT_MON_LO 11
`define ISS_BIT_DUAL 0
`define ISS_BIT_TRIPLE 1
`define ISS_BIT_PERIOD_INTERP 2
`define ISS_BIT_GATE_FIRST 8
`define ISS_SPI_READ_BIT 15
`endif

/* File: rtl/iss_seq_config.v */
// sequencer configuration registers over serial port, plus row-to-readout timing
`timescale 1ns/1ps
`include "iss_regs.vh"
module iss_seq_config (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // serial peripheral port
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_mosi,
    output reg spi_miso_r,
    // sequencer events
    input wire row_transfer_done,
    input wire line_start,
    input wire frame_start,
    // timing outputs
    output reg readout_start_r,
    output reg line_readout_extension_r,
    output reg timebase_tick_r,
    output reg gate_line_r,
    // mode outputs
    output reg rolling_mode_r,
    output reg subsample_r,
    output reg binning_r,
    output reg stat_window_only_r,
    output reg [2:0] monitor_sel_r,
    output reg dual_slope_r,
    output reg triple_slope_r,
    output reg period_interpretation_r,
    output reg [15:0] frame_or_reset_period_r,
    output reg [15:0] exposure_time_r,
    output reg [15:0] second_slope_exposure_r,
    output reg [7:0] dark_rows_r,
    output reg [11:0] padding_rows_r,
    output reg [7:0] window_sel_r
);
    // pin synchronisers
    reg [1:0] sck_s_r;
    reg [1:0] cs_s_r;
    reg [1:0] mosi_s_r;
    reg sck_d_r;
    wire sck_now;
    wire sck_rise;
    wire sck_fall;
    wire cs_act;
    assign sck_now = sck_s_r[1];
    assign sck_rise = sck_now && !sck_d_r;
    assign sck_fall = !sck_now && sck_d_r;
    assign cs_act = !cs_s_r[1];
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            mosi_s_r <= 2'h0;
            sck_d_r <= 1'b0;
        end else begin
            sck_s_r <= {sck_s_r[0], spi_sck};
            cs_s_r <= {cs_s_r[0], spi_cs_n};
            mosi_s_r <= {mosi_s_r[0], spi_mosi};
            sck_d_r <= sck_now;
        end
    end

    // register file
    reg [15:0] gen_r;
    reg [15:0] dly_r;
    reg [15:0] integ_r;
    reg [15:0] win_r;
    reg [15:0] dark_r;
    reg [15:0] pad_r;
    reg [15:0] tbm_r;
    reg [15:0] per_r;
    reg [15:0] exp_r;
    reg [15:0] exp2_r;

    // frame: 16-bit word, bit15 read flag, bits 8:0 address, then 16 data bits
    reg [5:0] bit_cnt_r;
    reg [15:0] hdr_r;
    reg [15:0] dat_r;
    reg [15:0] rd_sh_r;
    reg wr_stb_r;
    reg [8:0] wr_addr_r;
    reg [15:0] wr_data_r;
    reg [15:0] rd_val;
    wire [15:0] hdr_nxt;
    assign hdr_nxt = {hdr_r[14:0], mosi_s_r[1]};

    always @* begin
        case (hdr_nxt[8:0])
            `ISS_ADDR_GENERAL: rd_val = gen_r;
            `ISS_ADDR_DELAY: rd_val = dly_r;
            `ISS_ADDR_INTEG: rd_val = integ_r;
            `ISS_ADDR_WINDOW: rd_val = win_r;
            `ISS_ADDR_SPARE: rd_val = `ISS_RST_SPARE;
            `ISS_ADDR_DARK: rd_val = dark_r;
            `ISS_ADDR_PAD: rd_val = pad_r;
            `ISS_ADDR_TBMULT: rd_val = tbm_r;
            `ISS_ADDR_PERIOD: rd_val = per_r;
            `ISS_ADDR_EXPO: rd_val = exp_r;
            `ISS_ADDR_EXPO2: rd_val = exp2_r;
            default: rd_val = 16'h0000;
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= 6'h00;
            hdr_r <= 16'h0000;
            dat_r <= 16'h0000;
            rd_sh_r <= 16'h0000;
            spi_miso_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_addr_r <= 9'h000;
            wr_data_r <= 16'h0000;
        end else begin
            wr_stb_r <= 1'b0;
            if (!cs_act) begin
                bit_cnt_r <= 6'h00;
                spi_miso_r <= 1'b0;
            end else if (sck_rise && bit_cnt_r < 6'h20) begin
                bit_cnt_r <= bit_cnt_r + 6'h01;
                if (bit_cnt_r < 6'h10) begin
                    hdr_r <= hdr_nxt;
                    if (bit_cnt_r == 6'h0F) begin
                        rd_sh_r <= rd_val;
                    end
                end else begin
                    dat_r <= {dat_r[14:0], mosi_s_r[1]};
                    if (bit_cnt_r == 6'h1F && !hdr_r[`ISS_SPI_READ_BIT]) begin
                        wr_stb_r <= 1'b1;
                        wr_addr_r <= hdr_r[8:0];
                        wr_data_r <= {dat_r[14:0], mosi_s_r[1]};
                    end
                end
            end else if (sck_fall && bit_cnt_r >= 6'h10) begin
                spi_miso_r <= rd_sh_r[15];
                rd_sh_r <= {rd_sh_r[14:0], 1'b0};
            end
        end
    end

    // writes keep reserved bits at their defaults
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_r <= `ISS_RST_GENERAL;
            dly_r <= `ISS_RST_DELAY;
            integ_r <= `ISS_RST_INTEG;
            win_r <= `ISS_RST_WINDOW;
            dark_r <= `ISS_RST_DARK;
            pad_r <= `ISS_RST_PAD;
            tbm_r <= `ISS_RST_TBMULT;
            per_r <= `ISS_RST_PERIOD;
            exp_r <= `ISS_RST_EXPO;
            exp2_r <= `ISS_RST_EXPO2;
        end else if (wr_stb_r) begin
            case (wr_addr_r)
                `ISS_ADDR_GENERAL: gen_r <= wr_data_r & `ISS_MASK_GENERAL;
                `ISS_ADDR_DELAY: dly_r <= wr_data_r;
                `ISS_ADDR_INTEG: integ_r <= wr_data_r & `ISS_MASK_INTEG;
                `ISS_ADDR_WINDOW: win_r <= wr_data_r & `ISS_MASK_WINDOW;
                `ISS_ADDR_DARK: dark_r <= wr_data_r & `ISS_MASK_DARK;
                `ISS_ADDR_PAD: pad_r <= wr_data_r & `ISS_MASK_PAD;
                `ISS_ADDR_TBMULT: tbm_r <= wr_data_r;
                `ISS_ADDR_PERIOD: per_r <= wr_data_r;
                `ISS_ADDR_EXPO: exp_r <= wr_data_r;
                `ISS_ADDR_EXPO2: exp2_r <= wr_data_r;
                default: gen_r <= gen_r;
            endcase
        end
    end

    // decoded modes
    wire rolling;
    assign rolling = gen_r[`ISS_BIT_ROLLING];
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rolling_mode_r <= 1'b0;
            subsample_r <= 1'b0;
            binning_r <= 1'b0;
            stat_window_only_r <= 1'b0;
            monitor_sel_r <= 3'h0;
            dual_slope_r <= 1'b0;
            triple_slope_r <= 1'b0;
            period_interpretation_r <= 1'b1;
            frame_or_reset_period_r <= 16'h0000;
            exposure_time_r <= 16'h0000;
            second_slope_exposure_r <= 16'h0000;
            dark_rows_r <= 8'h01;
            padding_rows_r <= 12'h000;
            window_sel_r <= 8'h01;
        end else begin
            rolling_mode_r <= rolling;
            subsample_r <= gen_r[`ISS_BIT_SUBSAMPLE];
            binning_r <= gen_r[`ISS_BIT_BINNING];
            stat_window_only_r <= gen_r[`ISS_BIT_STAT_WIN];
            monitor_sel_r <= gen_r[`ISS_BIT_MON_LO+2:`ISS_BIT_MON_LO];
            dual_slope_r <= integ_r[`ISS_BIT_DUAL] && !rolling;
            triple_slope_r <= integ_r[`ISS_BIT_TRIPLE] && !rolling;
            period_interpretation_r <= integ_r[`ISS_BIT_PERIOD_INTERP];
            frame_or_reset_period_r <= rolling ? 16'h0000 : per_r;
            exposure_time_r <= exp_r;
            second_slope_exposure_r <= rolling ? 16'h0000 : exp2_r;
            // zero is illegal; clamp so the frame keeps one black line
            dark_rows_r <= (dark_r[7:0] == 8'h00) ? 8'h01 : dark_r[7:0];
            padding_rows_r <= rolling ? pad_r[11:0] : 12'h000;
            window_sel_r <= win_r[7:0];
        end
    end

    // first line of each frame is gated when enabled
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_line_r <= 1'b0;
        end else if (frame_start) begin
            gate_line_r <= dark_r[`ISS_BIT_GATE_FIRST];
        end else if (line_start) begin
            gate_line_r <= 1'b0;
        end
    end

    // timebase tick generator, global shutter only
    wire tb_zero;
    wire tb_load;
    assign tb_load = tb_zero || frame_start;
    iss_downcounter u_tb (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(tb_load),
        .load_val(tbm_r - 16'h0001),
        .tick(1'b1),
        .count_r(),
        .zero(tb_zero)
    );
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timebase_tick_r <= 1'b0;
        end else begin
            timebase_tick_r <= tb_zero && !rolling;
        end
    end

    // row transfer to readout gap
    reg dly_busy_r;
    wire dly_zero;
    wire dly_en;
    assign dly_en = gen_r[`ISS_BIT_DLY_EN] && (dly_r[15:8] != 8'h00);
    iss_downcounter u_dly (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(row_transfer_done),
        .load_val({8'h00, dly_r[15:8]}),
        .tick(dly_busy_r),
        .count_r(),
        .zero(dly_zero)
    );
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_busy_r <= 1'b0;
            readout_start_r <= 1'b0;
        end else begin
            readout_start_r <= 1'b0;
            if (row_transfer_done && !dly_en) begin
                readout_start_r <= 1'b1;
            end else if (row_transfer_done) begin
                dly_busy_r <= 1'b1;
            end else if (dly_busy_r && dly_zero) begin
                dly_busy_r <= 1'b0;
                readout_start_r <= 1'b1;
            end
        end
    end

    // extension of each rolling shutter line by dummy pixel cycles
    reg ext_arm_r;
    wire ext_zero;
    iss_downcounter u_ext (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(readout_start_r),
        .load_val({8'h00, dly_r[7:0]}),
        .tick(ext_arm_r),
        .count_r(),
        .zero(ext_zero)
    );
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_arm_r <= 1'b0;
            line_readout_extension_r <= 1'b0;
        end else begin
            if (readout_start_r) begin
                ext_arm_r <= rolling && (dly_r[7:0] != 8'h00);
            end else if (ext_arm_r && ext_zero) begin
                ext_arm_r <= 1'b0;
            end
            line_readout_extension_r <= ext_arm_r && !ext_zero;
        end
    end
endmodule

/* File: tb/iss_host_model.sv */
// behavioural host driving the serial configuration port
`timescale 1ns/1ps
module iss_host_model (
    // clock
    input wire core_clk,
    // serial port
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire spi_miso_r
);
    // serial clock stands low between frames
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // six core cycles per half period leave room for the pin synchronisers
    task xfer(input logic [15:0] hdr, input logic [15:0] dat, output logic [15:0] rd);
        integer i;
        logic [31:0] sh;
        if (hdr[8:0] == 9'h0C5 && dat[7:0] == 8'h00) dat[7:0] = 8'h01;
        sh = {hdr, dat};
        rd = 16'h0000;
        @(negedge core_clk) spi_cs_n = 1'b0;
        repeat (6) @(negedge core_clk);
        for (i = 31; i >= 0; i--) begin
            spi_mosi = sh[i];
            repeat (6) @(negedge core_clk);
            if (i < 16) rd = {rd[14:0], spi_miso_r};
            spi_sck = 1'b1;
            repeat (6) @(negedge core_clk);
            spi_sck = 1'b0;
        end
        repeat (6) @(negedge core_clk);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        repeat (8) @(negedge core_clk);
    endtask
endmodule

/* File: tb/iss_seq_config_bench.sv */
// self-checking bench for the sequencer configuration block
`timescale 1ns/1ps
`include "iss_regs.vh"
module iss_seq_config_bench;
    logic core_clk, rst_n, row_transfer_done, line_start, frame_start;
    wire spi_sck, spi_cs_n, spi_mosi, spi_miso_r, readout_start_r, line_readout_extension_r;
    wire timebase_tick_r, gate_line_r, rolling_mode_r, subsample_r, binning_r;
    wire stat_window_only_r, dual_slope_r, triple_slope_r, period_interpretation_r;
    wire [2:0] monitor_sel_r;
    wire [15:0] frame_or_reset_period_r, exposure_time_r, second_slope_exposure_r;
    wire [7:0] dark_rows_r, window_sel_r;
    wire [11:0] padding_rows_r;
    integer n_mismatch = 0;
    integer checked = 0;
    logic [15:0] rd_v;
    logic [15:0] rst_tab [0:10] = '{`ISS_RST_GENERAL, `ISS_RST_DELAY, `ISS_RST_INTEG,
        `ISS_RST_WINDOW, `ISS_RST_SPARE, `ISS_RST_DARK, `ISS_RST_PAD, `ISS_RST_TBMULT,
        `ISS_RST_PERIOD, `ISS_RST_EXPO, `ISS_RST_EXPO2};
    logic [15:0] msk_tab [0:10] = '{`ISS_MASK_GENERAL, 16'hFFFF, `ISS_MASK_INTEG,
        `ISS_MASK_WINDOW, 16'h0000, `ISS_MASK_DARK, `ISS_MASK_PAD, 16'hFFFF, 16'hFFFF,
        16'hFFFF, 16'hFFFF};
    iss_seq_config dut (.core_clk, .rst_n, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso_r,
        .row_transfer_done, .line_start, .frame_start, .readout_start_r,
        .line_readout_extension_r, .timebase_tick_r, .gate_line_r, .rolling_mode_r,
        .subsample_r, .binning_r, .stat_window_only_r, .monitor_sel_r, .dual_slope_r,
        .triple_slope_r, .period_interpretation_r, .frame_or_reset_period_r,
        .exposure_time_r, .second_slope_exposure_r, .dark_rows_r, .padding_rows_r,
        .window_sel_r);
    iss_host_model host (.core_clk, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso_r);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task give_verdict();
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [8:0] a, input logic [15:0] d);
        host.xfer({7'h00, a}, d, rd_v);
    endtask
    task rd_chk(input logic [8:0] a, input logic [15:0] e);
        host.xfer({7'h40, a}, 16'h0000, rd_v);
        check(rd_v, e);
    endtask
    // sel 0 row transfer done, 1 frame start, 2 line start
    task pulse(input integer sel);
        @(negedge core_clk);
        {line_start, frame_start, row_transfer_done} = 3'b001 << sel;
        @(negedge core_clk);
        {line_start, frame_start, row_transfer_done} = 3'b000;
    endtask
    task readout_lat(output integer lat, output integer ext);
        pulse(0);
        lat = 1;
        while (readout_start_r !== 1'b1 && lat < 300) begin
            @(negedge core_clk);
            lat++;
        end
        ext = 0;
        repeat (20) @(negedge core_clk) if (line_readout_extension_r === 1'b1) ext++;
    endtask
    task t_reset();
        integer i;
        check({period_interpretation_r, dark_rows_r, window_sel_r}, 17'h10201);
        for (i = 0; i < 11; i++) rd_chk(9'h0C0 + i[8:0], rst_tab[i]);
        rd_chk(9'h1FF, 16'h0000);
    endtask
    task t_masks();
        integer i;
        for (i = 0; i < 11; i++) wr(9'h0C0 + i[8:0], 16'hFFFF);
        for (i = 0; i < 11; i++) rd_chk(9'h0C0 + i[8:0], msk_tab[i]);
        check({rolling_mode_r, subsample_r, binning_r, stat_window_only_r}, 4'hF);
        check(monitor_sel_r, 3'h7);
        check({dual_slope_r, triple_slope_r, frame_or_reset_period_r}, 18'h0);
        check(second_slope_exposure_r, 16'h0000);
        check({padding_rows_r, dark_rows_r}, 20'hFFFFF);
        check(exposure_time_r, 16'hFFFF);
        check(window_sel_r, 8'hFF);
    endtask
    task t_global();
        wr(`ISS_ADDR_GENERAL, 16'h0000);
        check({rolling_mode_r, subsample_r, binning_r, stat_window_only_r}, 4'h0);
        check({dual_slope_r, triple_slope_r, period_interpretation_r}, 3'h7);
        check({frame_or_reset_period_r, second_slope_exposure_r}, 32'hFFFFFFFF);
        check(padding_rows_r, 12'h000);
        wr(`ISS_ADDR_INTEG, 16'h0000);
        check(period_interpretation_r, 1'b0);
    endtask
    task t_readout();
        integer lat, ext;
        wr(`ISS_ADDR_DELAY, 16'h0503);
        readout_lat(lat, ext);
        check({lat[15:0], ext[15:0]}, 32'h00010000);
        wr(`ISS_ADDR_GENERAL, 16'h0042);
        readout_lat(lat, ext);
        // delay of five: pulse seen five plus two cycles after the row transfer
        check({lat[15:0], ext[15:0]}, 32'h00070003);
        wr(`ISS_ADDR_DELAY, 16'h0003);
        readout_lat(lat, ext);
        check(lat, 1);
    endtask
    task t_timebase();
        integer gap;
        wr(`ISS_ADDR_GENERAL, 16'h0000);
        wr(`ISS_ADDR_TBMULT, 16'h0004);
        pulse(1);
        gap = 0;
        while (timebase_tick_r !== 1'b1 && gap < 100) @(negedge core_clk) gap++;
        @(negedge core_clk) gap = 1;
        while (timebase_tick_r !== 1'b1 && gap < 100) @(negedge core_clk) gap++;
        check(gap, 4);
    endtask
    task t_gate();
        wr(`ISS_ADDR_DARK, 16'h0102);
        pulse(1);
        check(gate_line_r, 1'b1);
        pulse(2);
        check(gate_line_r, 1'b0);
        wr(`ISS_ADDR_DARK, 16'h0002);
        pulse(1);
        check({gate_line_r, dark_rows_r}, 9'h002);
    endtask
    initial begin
        rst_n = 1'b0;
        {line_start, frame_start, row_transfer_done} = 3'b000;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_reset();
        t_masks();
        t_global();
        t_readout();
        t_timebase();
        t_gate();
        give_verdict();
    end
    initial begin
        #300000;
        n_mismatch++;
        give_verdict();
    end
endmodule

/* File: tb/iss_seq_monitor.sv */
// assertion checker watching the sequencer configuration ports
`timescale 1ns/1ps
module iss_seq_monitor (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // events
    input wire row_transfer_done,
    input wire line_start,
    input wire frame_start,
    // watched outputs
    input wire readout_start_r,
    input wire line_readout_extension_r,
    input wire timebase_tick_r,
    input wire gate_line_r,
    input wire rolling_mode_r,
    input wire dual_slope_r,
    input wire triple_slope_r,
    input wire [15:0] frame_or_reset_period_r,
    input wire [15:0] second_slope_exposure_r,
    input wire [7:0] dark_rows_r,
    input wire [11:0] padding_rows_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // longest gap is a delay of 255 plus two cycles
    sequence s_readout_wait;
        ##[1:257] readout_start_r;
    endsequence
    sequence s_pulse_gone;
        readout_start_r ##1 !readout_start_r;
    endsequence
    a_readout_follows_row: assert property (row_transfer_done |-> s_readout_wait)
        else $error("readout did not follow row transfer");
    a_readout_one_cycle: assert property (readout_start_r |-> s_pulse_gone)
        else $error("readout pulse longer than one cycle");
    a_dual_global_only: assert property (dual_slope_r |-> !rolling_mode_r)
        else $error("dual slope on in rolling mode");
    a_triple_global_only: assert property (triple_slope_r |-> !rolling_mode_r)
        else $error("triple slope on in rolling mode");
    a_period_rolling_zero: assert property (rolling_mode_r |-> frame_or_reset_period_r == 0)
        else $error("period not zero in rolling mode");
    a_second_rolling_zero: assert property (rolling_mode_r |-> second_slope_exposure_r == 0)
        else $error("second slope exposure not zero in rolling mode");
    a_pad_global_zero: assert property (!rolling_mode_r |-> padding_rows_r == 0)
        else $error("padding rows not zero in global mode");
    a_dark_never_zero: assert property (dark_rows_r != 8'h00)
        else $error("dark row count is zero");
    a_ext_rolling_only: assert property (line_readout_extension_r |-> rolling_mode_r)
        else $error("line extension in global mode");
    a_tick_global_only: assert property (timebase_tick_r |-> !rolling_mode_r)
        else $error("timebase tick in rolling mode");
    a_gate_line_clear: assert property (line_start && !frame_start |=> !gate_line_r)
        else $error("gate not cleared by line start");
endmodule
bind iss_seq_config iss_seq_monitor u_mon (.core_clk, .rst_n, .row_transfer_done, .line_start,
    .frame_start, .readout_start_r, .line_readout_extension_r, .timebase_tick_r, .gate_line_r,
    .rolling_mode_r, .dual_slope_r, .triple_slope_r, .frame_or_reset_period_r,
    .second_slope_exposure_r, .dark_rows_r, .padding_rows_r);
